/* File: rtl/cis_core.sv */
// Instruction execution sequencer with workspace memory port and context registers
`timescale 1ns/1ns
module cis_core import cis_pkg::*; (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic start, // Start pulse for op_in
  input wire cis_op_t op_in, // Operation to execute
  input wire logic [15:0] sa_in, // Source address
  input wire logic [3:0] dfield_in, // Destination register / trap number
  input wire logic ctx_load, // Load pc/wp while idle
  input wire logic [15:0] pc_load, // Program counter to load
  input wire logic [15:0] wp_load, // Workspace pointer to load
  input wire logic [2:0] interrupt_request_inputs, // Request pins, asynchronous
  output logic busy, // Instruction in progress
  output logic done, // Instruction finished pulse
  output logic irq_take, // Interrupt to be taken at this boundary
  output logic [2:0] irq_level, // Request level sampled at boundary
  output logic [15:0] pc, // Program counter
  output logic [15:0] wp, // Workspace pointer
  output logic [15:0] flags_word, // Status flags
  output logic exec_valid, // Word fetched for execute is valid
  output logic [15:0] exec_word, // Instruction word to execute
  output logic mem_req, // Memory access request
  output logic mem_we, // Write when high
  output logic [15:0] mem_addr, // Word address in bytes
  output logic [15:0] mem_wdata, // Write data
  input wire logic mem_ack, // Access completes this cycle
  input wire logic [15:0] mem_rdata // Read data, valid with ack
);

  typedef struct packed {
    cis_state_t st; // Sequencer state
    cis_op_t op; // Latched operation
    logic [15:0] sa; // Source address
    logic [15:0] wa; // Destination write address
    logic [15:0] src; // Source operand
    logic [15:0] dh; // Destination word
    logic [15:0] dl; // Following word
    logic [15:0] rh; // First result word
    logic [15:0] rl; // Second result word
    logic [15:0] pc; // Program counter
    logic [15:0] wp; // Workspace pointer
    logic [15:0] flg; // flags_word
    logic [15:0] npc; // Pending program counter
    logic [15:0] nwp; // Pending workspace pointer
    logic [15:0] xw; // Fetched execute word
    logic [1:0] wcnt; // Context save index
    logic [2:0] irq1; // Synchroniser stage one
    logic [2:0] irq2; // Synchroniser stage two
    logic [2:0] lvl; // Level sampled at boundary
    logic done; // Finish pulse
    logic irq; // Interrupt take pulse
    logic xv; // Execute word pulse
    logic divgo; // Divider start pulse
  } cis_core_st_t;

  cis_core_st_t q, d;
  logic [15:0] alu_res; // ALU result
  logic alu_eq; // Compare outcome
  logic div_done; // Divider finished
  logic [31:0] div_quot; // Divider quotient magnitude
  logic [15:0] div_rem; // Divider remainder magnitude
  logic [31:0] dvd_mag; // Dividend magnitude
  logic [15:0] dvs_mag; // Divisor magnitude
  logic [31:0] prod_u; // Unsigned product
  logic signed [31:0] prod_s; // Signed product
  logic q_neg; // Signed quotient is negative
  logic s_ovf; // Signed quotient out of range
  logic two_word; // Result takes two words
  logic fin; // Instruction ends this cycle
  logic [3:0] ctx_idx; // Register receiving context word

  cis_word_alu u_alu (
    .op(q.op),
    .src(q.src),
    .dst(q.dh),
    .res(alu_res),
    .eq(alu_eq)
  );

  cis_divider #(.W(16)) u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(q.divgo),
    .dividend(dvd_mag),
    .divisor(dvs_mag),
    .done(div_done),
    .quot(div_quot),
    .rem(div_rem)
  );

  // Arithmetic helpers; signed divide works on magnitudes and fixes signs after
  always_comb begin
    prod_u = q.dh * q.src;
    prod_s = $signed(q.dh) * $signed(q.src);
    dvd_mag = (q.op == OP_SIGNED_QUOTIENT && q.dh[15]) ? 32'(-{q.dh, q.dl}) : {q.dh, q.dl};
    dvs_mag = (q.op == OP_SIGNED_QUOTIENT && q.src[15]) ? 16'(-q.src) : q.src;
    q_neg = q.dh[15] ^ q.src[15];
    // Negative side may reach one step further than positive
    s_ovf = q_neg ? (div_quot > {16'h0000, SMIN_MAG}) : (div_quot > {16'h0000, SMAX_POS});
    two_word = (q.op == OP_UNSIGNED_PRODUCT) || (q.op == OP_UNSIGNED_QUOTIENT) ||
               (q.op == OP_SIGNED_PRODUCT) || (q.op == OP_SIGNED_QUOTIENT);
    ctx_idx = 4'(SAVE_WP_REG + {2'b00, q.wcnt});
  end

  // Memory port driven straight from the state, so the request holds until ack
  always_comb begin
    mem_req = 1'b1;
    mem_we = 1'b0;
    mem_wdata = q.rh;
    mem_addr = q.sa;
    case (q.st)
      S_RSRC: mem_addr = q.sa;
      S_RSRC2: mem_addr = 16'(q.sa + 16'h0002);
      S_RDST: mem_addr = q.wa;
      S_RDST2: mem_addr = 16'(q.wa + 16'h0002);
      S_WR1: mem_we = 1'b1;
      S_WR2: begin
        mem_we = 1'b1;
        mem_addr = 16'(q.wa + 16'h0002);
        mem_wdata = q.rl;
      end
      S_CTX: begin
        mem_we = 1'b1;
        mem_addr = 16'(q.nwp + {11'h000, ctx_idx, 1'b0});
        mem_wdata = (q.wcnt == 2'h0) ? q.wp : ((q.wcnt == 2'h1) ? q.pc : q.flg);
      end
      default: mem_req = 1'b0; // No access while idle or computing
    endcase
    if (q.st == S_WR1) begin
      mem_addr = q.wa;
    end
  end

  // Sequencer next state
  always_comb begin
    d = q;
    fin = 1'b0;
    d.done = 1'b0;
    d.irq = 1'b0;
    d.xv = 1'b0;
    d.divgo = 1'b0;
    d.irq1 = interrupt_request_inputs;
    d.irq2 = q.irq1;
    case (q.st)
      S_IDLE: begin
        if (ctx_load) begin
          d.pc = pc_load;
          d.wp = wp_load;
        end else if (start) begin
          d.op = op_in;
          d.sa = sa_in;
          d.wa = 16'(q.wp + {11'h000, dfield_in, 1'b0});
          d.st = S_RSRC;
          case (op_in)
            OP_JUMP: begin
              d.pc = sa_in;
              fin = 1'b1;
            end
            OP_JUMP_WITH_LINK: begin
              d.wa = 16'(q.wp + {11'h000, LINK_REG, 1'b0});
              d.rh = q.pc;
              d.npc = sa_in;
              d.st = S_WR1;
            end
            OP_EXTENDED_TRAP_OP: d.sa = 16'(XOP_BASE + {10'h000, dfield_in, 2'b00});
            OP_SIGNED_PRODUCT, OP_SIGNED_QUOTIENT: d.wa = q.wp;
            default: d.st = S_RSRC; // Fetch source first
          endcase
        end
      end
      S_RSRC: begin
        if (mem_ack) begin
          d.src = mem_rdata;
          if (q.op == OP_CONTEXT_JUMP || q.op == OP_EXTENDED_TRAP_OP) begin
            d.nwp = mem_rdata;
            d.st = S_RSRC2;
          end else if (q.op == OP_EXECUTE) begin
            d.xw = mem_rdata;
            d.xv = 1'b1;
            fin = 1'b1;
          end else if (cis_is_unary(q.op)) begin
            d.st = S_CALC;
          end else begin
            d.st = S_RDST;
          end
        end
      end
      S_RSRC2: begin
        if (mem_ack) begin
          d.npc = mem_rdata;
          d.wcnt = 2'h0;
          d.st = S_CTX;
        end
      end
      S_RDST: begin
        if (mem_ack) begin
          d.dh = mem_rdata;
          if (q.op == OP_UNSIGNED_QUOTIENT || q.op == OP_SIGNED_QUOTIENT) begin
            d.st = S_RDST2;
          end else begin
            d.st = S_CALC;
          end
        end
      end
      S_RDST2: begin
        if (mem_ack) begin
          d.dl = mem_rdata;
          d.st = S_CALC;
        end
      end
      S_CALC: begin
        d.st = S_WR1;
        d.rh = alu_res;
        case (q.op)
          OP_COMPARE_ONES_CORRESPONDING, OP_COMPARE_ZEROS_CORRESPONDING: begin
            d.flg[FLG_EQ] = alu_eq;
            fin = 1'b1;
          end
          OP_UNSIGNED_PRODUCT: {d.rh, d.rl} = prod_u;
          OP_SIGNED_PRODUCT: {d.rh, d.rl} = prod_s;
          OP_UNSIGNED_QUOTIENT: begin
            if (q.src <= q.dh) begin
              d.flg[FLG_OVF] = 1'b1;
              fin = 1'b1;
            end else begin
              d.divgo = 1'b1;
              d.st = S_DIVW;
            end
          end
          OP_SIGNED_QUOTIENT: begin
            d.divgo = 1'b1;
            d.st = S_DIVW;
          end
          default: d.wa = cis_is_unary(q.op) ? q.sa : q.wa;
        endcase
      end
      S_DIVW: begin
        if (div_done) begin
          d.flg[FLG_OVF] = 1'b0;
          d.st = S_WR1;
          if (q.op == OP_UNSIGNED_QUOTIENT) begin
            d.rh = div_quot[15:0];
            d.rl = div_rem;
          end else if (s_ovf) begin
            d.flg[FLG_OVF] = 1'b1;
            fin = 1'b1;
          end else begin
            d.rh = q_neg ? 16'(-div_quot[15:0]) : div_quot[15:0];
            d.rl = q.dh[15] ? 16'(-div_rem) : div_rem;
          end
        end
      end
      S_WR1: begin
        if (mem_ack) begin
          if (two_word) begin
            d.st = S_WR2;
          end else begin
            if (q.op == OP_JUMP_WITH_LINK) begin
              d.pc = q.npc;
            end
            fin = 1'b1;
          end
        end
      end
      S_WR2: begin
        if (mem_ack) begin
          fin = 1'b1;
        end
      end
      S_CTX: begin
        if (mem_ack) begin
          if (q.wcnt == CTX_LAST) begin
            d.wp = q.nwp;
            d.pc = q.npc;
            fin = 1'b1;
          end else begin
            d.wcnt = 2'(q.wcnt + 2'h1);
          end
        end
      end
      default: d.st = S_IDLE; // Recover from an illegal code
    endcase
    // Boundary: interrupts are looked at except after a context jump
    if (fin) begin
      d.st = S_IDLE;
      d.done = 1'b1;
      d.lvl = q.irq2;
      d.irq = (q.irq2 != IRQ_NONE) && (q.op != OP_CONTEXT_JUMP);
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{st: S_IDLE, op: OP_JUMP, pc: PC_RST, wp: WP_RST, flg: FLAGS_RST,
             irq1: IRQ_NONE, irq2: IRQ_NONE, lvl: IRQ_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign busy = (q.st != S_IDLE);
  assign done = q.done;
  assign irq_take = q.irq;
  assign irq_level = q.lvl;
  assign pc = q.pc;
  assign wp = q.wp;
  assign flags_word = q.flg;
  assign exec_valid = q.xv;
  assign exec_word = q.xw;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_link_issue;
    q.st == S_IDLE && !ctx_load && start && op_in == OP_JUMP_WITH_LINK;
  endsequence

  property p_link;
    s_link_issue |=> mem_we && mem_addr == 16'($past(q.wp) + 16'h0016) && mem_wdata == $past(q.pc);
  endproperty
  a_link: assert property (p_link) else $error("link word wrong");

  property p_trap_vec;
    q.st == S_IDLE && !ctx_load && start && op_in == OP_EXTENDED_TRAP_OP
      |=> mem_req && mem_addr == 16'(16'h0040 + {10'h000, $past(dfield_in), 2'b00});
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector address wrong");

  property p_div_ovf;
    q.st == S_CALC && q.op == OP_UNSIGNED_QUOTIENT && q.src <= q.dh
      |=> done && flags_word[4] && !mem_req;
  endproperty
  a_div_ovf: assert property (p_div_ovf) else $error("divide overflow not flagged");

  property p_uprod;
    q.st == S_CALC && q.op == OP_UNSIGNED_PRODUCT |=> {q.rh, q.rl} == $past(q.dh) * $past(q.src);
  endproperty
  a_uprod: assert property (p_uprod) else $error("unsigned product wrong");

  property p_coc;
    q.st == S_CALC && q.op == OP_COMPARE_ONES_CORRESPONDING
      |=> flags_word[2] == (($past(q.dh) & $past(q.src)) == $past(q.src));
  endproperty
  a_coc: assert property (p_coc) else $error("ones compare wrong");

  property p_czc;
    q.st == S_CALC && q.op == OP_COMPARE_ZEROS_CORRESPONDING
      |=> flags_word[2] == (($past(q.dh) & $past(q.src)) == 16'h0000);
  endproperty
  a_czc: assert property (p_czc) else $error("zeros compare wrong");

  property p_ctx_noirq;
    q.st == S_CTX && mem_ack && q.wcnt == 2'h2 && q.op == OP_CONTEXT_JUMP
      |=> done && !irq_take && wp == $past(q.nwp);
  endproperty
  a_ctx_noirq: assert property (p_ctx_noirq) else $error("context jump boundary wrong");

  property p_rem_sign;
    q.st == S_DIVW && div_done && q.op == OP_SIGNED_QUOTIENT && !s_ovf
      |=> q.rl == 16'h0000 || q.rl[15] == q.dh[15];
  endproperty
  a_rem_sign: assert property (p_rem_sign) else $error("remainder sign wrong");

  property p_swap;
    q.st == S_CALC && q.op == OP_BYTE_SWAP |=> q.rh == {$past(q.src[7:0]), $past(q.src[15:8])} && mem_we;
  endproperty
  a_swap: assert property (p_swap) else $error("byte swap wrong");

endmodule

/* File: rtl/cis_pkg.sv */
// Package of opcodes, states, flag positions and constants for the instruction execution unit
package cis_pkg;

  // Operation codes presented on the command port
  typedef enum logic [4:0] {
    OP_COMPARE_ONES_CORRESPONDING = 5'h00,
    OP_COMPARE_ZEROS_CORRESPONDING = 5'h01,
    OP_XOR = 5'h02,
    OP_UNSIGNED_PRODUCT = 5'h03,
    OP_UNSIGNED_QUOTIENT = 5'h04,
    OP_SIGNED_PRODUCT = 5'h05,
    OP_SIGNED_QUOTIENT = 5'h06,
    OP_EXTENDED_TRAP_OP = 5'h07,
    OP_JUMP = 5'h08,
    OP_JUMP_WITH_LINK = 5'h09,
    OP_CONTEXT_JUMP = 5'h0a,
    OP_ZERO_FILL = 5'h0b,
    OP_ALL_ONES_FILL = 5'h0c,
    OP_BITWISE_COMPLEMENT = 5'h0d,
    OP_TWOS_COMPLEMENT_FLIP = 5'h0e,
    OP_MAGNITUDE_OP = 5'h0f,
    OP_BYTE_SWAP = 5'h10,
    OP_ADD_ONE = 5'h11,
    OP_ADD_TWO = 5'h12,
    OP_SUBTRACT_ONE = 5'h13,
    OP_SUBTRACT_TWO = 5'h14,
    OP_EXECUTE = 5'h15
  } cis_op_t;

  // Sequencer states, one-hot
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_RSRC = 10'h002,
    S_RSRC2 = 10'h004,
    S_RDST = 10'h008,
    S_RDST2 = 10'h010,
    S_CALC = 10'h020,
    S_DIVW = 10'h040,
    S_WR1 = 10'h080,
    S_WR2 = 10'h100,
    S_CTX = 10'h200
  } cis_state_t;

  localparam int FLG_EQ = 2; // Equal flag position in flags_word
  localparam int FLG_OVF = 4; // Overflow flag position in flags_word
  localparam logic [15:0] FLAGS_RST = 16'h0000; // flags_word after reset
  localparam logic [15:0] PC_RST = 16'h0000; // Program counter after reset
  localparam logic [15:0] WP_RST = 16'h0000; // Workspace pointer after reset
  localparam logic [15:0] XOP_BASE = 16'h0040; // Trap vector table base
  localparam logic [3:0] LINK_REG = 4'hb; // Register 11 takes the return address
  localparam logic [3:0] SAVE_WP_REG = 4'hd; // Registers 13..15 take the old context
  localparam logic [1:0] CTX_LAST = 2'h2; // Index of last context save word
  localparam int WS_WORDS = 16; // Words in one workspace
  localparam logic [15:0] ALL_ONES = 16'hffff; // Fill value for all-ones fill
  localparam logic [15:0] SMAX_POS = 16'h7fff; // Largest positive quotient
  localparam logic [15:0] SMIN_MAG = 16'h8000; // Largest negative quotient magnitude
  localparam logic [2:0] IRQ_NONE = 3'h7; // Request pins all high: nothing pending

  // Single-operand operations that write back to the source word
  function automatic logic cis_is_unary(input cis_op_t op);
    cis_is_unary = (op >= OP_ZERO_FILL) && (op <= OP_SUBTRACT_TWO);
  endfunction

endpackage

/* File: rtl/cis_word_alu.sv */
// Combinational word ALU for logic, compare and single-operand operations
`timescale 1ns/1ns
module cis_word_alu import cis_pkg::*; (
  input wire cis_op_t op, // Operation being executed
  input wire logic [15:0] src, // Source operand word
  input wire logic [15:0] dst, // Destination operand word
  output logic [15:0] res, // Result word
  output logic eq // Compare outcome
);

  // Result selection per operation
  always_comb begin
    case (op)
      OP_XOR: res = dst ^ src;
      OP_ZERO_FILL: res = 16'h0000;
      OP_ALL_ONES_FILL: res = ALL_ONES;
      OP_BITWISE_COMPLEMENT: res = ~src;
      OP_TWOS_COMPLEMENT_FLIP: res = 16'(-src);
      OP_MAGNITUDE_OP: res = src[15] ? 16'(-src) : src;
      OP_BYTE_SWAP: res = {src[7:0], src[15:8]};
      OP_ADD_ONE: res = 16'(src + 16'h0001);
      OP_ADD_TWO: res = 16'(src + 16'h0002);
      OP_SUBTRACT_ONE: res = 16'(src - 16'h0001);
      OP_SUBTRACT_TWO: res = 16'(src - 16'h0002);
      default: res = src; // Pass through
    endcase
  end

  // Compare: source acts as the mask of positions to test
  always_comb begin
    case (op)
      OP_COMPARE_ONES_CORRESPONDING: eq = ((dst & src) == src);
      OP_COMPARE_ZEROS_CORRESPONDING: eq = ((dst & src) == 16'h0000);
      default: eq = 1'b0; // Unused outside compares
    endcase
  end

endmodule

/* File: rtl/cis_divider.sv */
// Sequential restoring divider, double-width dividend by single-width divisor
`timescale 1ns/1ns
module cis_divider #(
  parameter int W = 16 // Divisor width; dividend and quotient are 2W
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic start, // One-cycle start pulse
  input wire logic [2*W-1:0] dividend, // Held stable while busy
  input wire logic [W-1:0] divisor, // Held stable while busy
  output logic done, // One-cycle pulse, results valid
  output logic [2*W-1:0] quot, // Quotient
  output logic [W-1:0] rem // Remainder
);

  typedef struct packed {
    logic [W:0] r; // Partial remainder
    logic [2*W-1:0] qt; // Shifting dividend / quotient
    logic [7:0] cnt; // Steps left
    logic busy; // Iterating
    logic done; // Finish pulse
  } cis_div_st_t;

  cis_div_st_t q, d;
  logic [W:0] sh; // Remainder shifted with next dividend bit

  // One quotient bit per cycle; 2W cycles trade speed for area
  always_comb begin
    d = q;
    d.done = 1'b0;
    sh = {q.r[W-1:0], q.qt[2*W-1]};
    if (start) begin
      d.r = '0;
      d.qt = dividend;
      d.cnt = 8'(2 * W);
      d.busy = 1'b1;
    end else if (q.busy) begin
      if (sh >= {1'b0, divisor}) begin
        d.r = sh - {1'b0, divisor};
        d.qt = {q.qt[2*W-2:0], 1'b1};
      end else begin
        d.r = sh;
        d.qt = {q.qt[2*W-2:0], 1'b0};
      end
      d.cnt = 8'(q.cnt - 8'h01);
      if (q.cnt == 8'h01) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
  assign quot = q.qt;
  assign rem = q.r[W-1:0];

endmodule

/* File: verif/cis_mem_model.sv */
// Behavioural word memory on the far side of the core's access port
`timescale 1ns/1ns
module cis_mem_model (
  input wire logic clk_sys, // System clock
  input wire logic [3:0] lat, // Wait cycles before each answer
  input wire logic mem_req, // Access pending
  input wire logic mem_we, // Write when high
  input wire logic [15:0] mem_addr, // Byte address of a word
  input wire logic [15:0] mem_wdata, // Write data
  output logic mem_ack, // Access completes
  output logic [15:0] mem_rdata // Read data with ack
);
  logic [15:0] m [0:32767]; // Word store, indexed by address bits 15..1
  logic [3:0] cnt = 4'h0; // Wait cycles spent on this access
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  // Answer off the falling edge; one idle cycle between accesses
  always @(negedge clk_sys) begin
    if (mem_ack) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (mem_req && cnt >= lat) begin
      mem_ack <= 1'b1;
    end else if (mem_req) begin
      cnt <= cnt + 4'h1;
    end
  end
  // Data toggles outside ack so a stale word can never pass as valid
  always @(negedge clk_sys) begin
    if (mem_req && !mem_ack && cnt >= lat) begin
      mem_rdata <= m[mem_addr[15:1]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
  // Whole-word write taken at the acknowledging edge
  always @(posedge clk_sys) begin
    if (mem_req && mem_ack && mem_we) begin
      m[mem_addr[15:1]] <= mem_wdata;
    end
  end
endmodule

/* File: verif/cis_tb_top.sv */
// Self-checking bench for the instruction execution core
`timescale 1ns/1ns
module cis_tb_top import cis_pkg::*;;
  localparam logic [15:0] SA = 16'h0200; // Source word address
  localparam logic [15:0] M_EQ = 16'h0001 << FLG_EQ; // Equal flag mask
  localparam logic [15:0] M_OV = 16'h0001 << FLG_OVF; // Overflow flag mask
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  cis_op_t op_in = OP_XOR;
  logic [15:0] sa_in = 16'h0000;
  logic [3:0] dfield_in = 4'h0;
  logic ctx_load = 1'b0;
  logic [15:0] pc_load = 16'h0000;
  logic [15:0] wp_load = 16'h0100;
  logic [2:0] interrupt_request_inputs = 3'h7;
  logic [3:0] lat = 4'h0;
  logic busy, done, irq_take, exec_valid, mem_req, mem_we, mem_ack;
  logic [2:0] irq_level;
  logic [15:0] pc, wp, flags_word, exec_word, mem_addr, mem_wdata, mem_rdata;
  int bad_count = 0;
  int tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  cis_core cis_core_i (.clk_sys, .reset_n, .start, .op_in, .sa_in, .dfield_in, .ctx_load, .pc_load,
    .wp_load, .interrupt_request_inputs, .busy, .done, .irq_take, .irq_level, .pc, .wp, .flags_word,
    .exec_valid, .exec_word, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  cis_mem_model cis_mem_model_i (.clk_sys, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Workspace register address, fixed workspace at 0100
  function automatic logic [15:0] wa(input logic [3:0] n);
    wa = 16'h0100 + {11'h000, n, 1'b0};
  endfunction
  function automatic logic [15:0] rd(input logic [15:0] a);
    rd = cis_mem_model_i.m[a[15:1]];
  endfunction
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    cis_mem_model_i.m[a[15:1]] = v;
  endtask
  // One-cycle start, then a bounded wait for the done pulse
  task automatic run(input cis_op_t op, input logic [15:0] sa, input logic [3:0] d);
    int i;
    @(negedge clk_sys);
    op_in = op;
    sa_in = sa;
    dfield_in = d;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    for (i = 0; i < 300 && done !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({14'h0000, done, busy}, 16'h0002);
  endtask
  task automatic op2(input cis_op_t op, input logic [3:0] d, input logic [15:0] dv, input logic [15:0] sv);
    wr(wa(d), dv);
    wr(SA, sv);
    run(op, SA, d);
  endtask
  task automatic t_logic();
    lat = 4'h2;
    op2(OP_XOR, 3, 16'ha5a5, 16'h0ff0);
    chk(rd(wa(3)), 16'haa55);
    op2(OP_COMPARE_ONES_CORRESPONDING, 3, 16'hf0f0, 16'ha0a0);
    chk(flags_word & M_EQ, M_EQ);
    op2(OP_COMPARE_ONES_CORRESPONDING, 3, 16'hf0f0, 16'h0f01);
    chk(flags_word & M_EQ, 16'h0000);
    op2(OP_COMPARE_ZEROS_CORRESPONDING, 3, 16'hf0f0, 16'h0f0f);
    chk(flags_word & M_EQ, M_EQ);
    op2(OP_COMPARE_ZEROS_CORRESPONDING, 3, 16'hf0f0, 16'h1000);
    chk(flags_word & M_EQ, 16'h0000);
    $display("t_logic done");
  endtask
  // Single-operand codes are contiguous, so one table covers all ten
  task automatic t_unary();
    logic [15:0] vi [10] = '{16'h1234, 16'h1234, 16'h1234, 16'h0001, 16'hfffe, 16'h1234, 16'hffff,
      16'hfffe, 16'h0000, 16'h0001};
    logic [15:0] ve [10] = '{16'h0000, 16'hffff, 16'hedcb, 16'hffff, 16'h0002, 16'h3412, 16'h0000,
      16'h0000, 16'hffff, 16'hffff};
    lat = 4'h0;
    for (int i = 0; i < 10; i++) begin
      wr(SA, vi[i]);
      run(cis_op_t'(5'(11 + i)), SA, 4'h0);
      chk(rd(SA), ve[i]);
    end
    $display("t_unary done");
  endtask
  task automatic t_arith();
    lat = 4'h1;
    op2(OP_UNSIGNED_PRODUCT, 3, 16'hffff, 16'hffff);
    chk(rd(wa(3)), 16'hfffe);
    chk(rd(wa(4)), 16'h0001);
    wr(wa(4), 16'h1234);
    op2(OP_UNSIGNED_QUOTIENT, 3, 16'h0005, 16'h0005);
    chk(rd(wa(3)), 16'h0005);
    chk(rd(wa(4)), 16'h1234);
    chk(flags_word & M_OV, M_OV);
    wr(wa(4), 16'h0000);
    op2(OP_UNSIGNED_QUOTIENT, 3, 16'h0001, 16'h0003);
    chk(rd(wa(3)), 16'h5555);
    chk(rd(wa(4)), 16'h0001);
    chk(flags_word & M_OV, 16'h0000);
    op2(OP_SIGNED_PRODUCT, 0, 16'hfffe, 16'h0003);
    chk(rd(wa(0)), 16'hffff);
    chk(rd(wa(1)), 16'hfffa);
    wr(wa(1), 16'hfff9);
    op2(OP_SIGNED_QUOTIENT, 0, 16'hffff, 16'h0002);
    chk(rd(wa(0)), 16'hfffd);
    chk(rd(wa(1)), 16'hffff);
    wr(wa(1), 16'h0000);
    op2(OP_SIGNED_QUOTIENT, 0, 16'hffff, 16'h0002);
    chk(rd(wa(0)), 16'h8000);
    wr(wa(1), 16'h0000);
    op2(OP_SIGNED_QUOTIENT, 0, 16'h0001, 16'h0001);
    chk(rd(wa(0)), 16'h0001);
    chk(flags_word & M_OV, M_OV);
    $display("t_arith done");
  endtask
  // Pending request pins show which boundaries sample them
  task automatic t_flow();
    logic [15:0] f;
    @(negedge clk_sys);
    interrupt_request_inputs = 3'h5;
    run(OP_JUMP, 16'h0300, 4'h0);
    chk(pc, 16'h0300);
    run(OP_JUMP_WITH_LINK, 16'h0400, 4'h0);
    chk(pc, 16'h0400);
    chk(rd(wa(11)), 16'h0300);
    wr(SA, 16'h0180);
    wr(SA + 16'h0002, 16'h0500);
    f = flags_word;
    run(OP_CONTEXT_JUMP, SA, 4'h0);
    chk(wp, 16'h0180);
    chk(pc, 16'h0500);
    chk({15'h0000, irq_take}, 16'h0000);
    chk(rd(16'h019a), 16'h0100);
    chk(rd(16'h019c), 16'h0400);
    chk(rd(16'h019e), f);
    wr(16'h0048, 16'h01c0);
    wr(16'h004a, 16'h0600);
    run(OP_EXTENDED_TRAP_OP, SA, 4'h2);
    chk(wp, 16'h01c0);
    chk(pc, 16'h0600);
    chk({15'h0000, irq_take}, 16'h0001);
    chk({13'h0000, irq_level}, 16'h0005);
    wr(SA, 16'h1234);
    run(OP_EXECUTE, SA, 4'h0);
    chk(exec_word, 16'h1234);
    chk({15'h0000, exec_valid}, 16'h0001);
    $display("t_flow done");
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    ctx_load = 1'b1;
    @(negedge clk_sys);
    ctx_load = 1'b0;
    chk(wp, 16'h0100);
    t_logic();
    t_unary();
    t_arith();
    t_flow();
    wrap_up();
  end
  // Whole run needs under a thousand cycles; this allows 30000 cycles
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end
endmodule
